// *** hdl/bsf_pkg.sv ***
// constants, types and register map of the boot security fuse status block
// Function
// (R1) pin code picks boot source, 0 reserved
// (R2) forced fabric fuse overrides pins and clock-select
// (R3) status bits 31:27 and 15:12 reserved
// (R4) bits 26:23 show clock-select fuses
// (R5) bit 22 debug fuse seeds debug domains
// (R6) bit 21 locks boundary-scan access level
// (R7) bit 20 locks debug-port access level
// (R8) bits 19/18 lock core0/core1 debug levels
// (R9) bit 17 locks trace infrastructure level
// (R10) bit 16 locks fabric debug level
// (R11) bit 11 picks tamper RAM clear order
// (R12) bit 10 clears RAMs on cold reset
// (R13) bit 9 clears RAMs on warm reset
// (R14) bit 8 blocks on-chip RAM second-stage boot
// (R15) bit 7 picks boot clock source
// (R16) bit 5 forces image decryption
// (R17) bits 4:2 report key authorization source
// (R18) bit 1 reports key length 256/384
// (R19) bit 0 forces image authentication
// (R20) bypass fuse permanently leaves scan chain
// (R21) boot and fabric bring-up in any order
// (R22) fuse status word readable by software
// (R23) clock-select code 0xf forces bypass mode
// (R24) fuse status word is read-only
package bsf_pkg;

   // register byte offsets
   localparam logic [7:0]  OFS_FUSE_STATUS = 8'h00;
   localparam logic [7:0]  OFS_BOOT_STATUS = 8'h04;
   localparam logic [7:0]  OFS_DEBUG_CTRL  = 8'h08;
   localparam logic [7:0]  OFS_SEC_LEVEL   = 8'h0c;
   localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

   // fuse status word fields
   localparam int FS_CLKSEL_LSB   = 23;
   localparam int FS_DBG_ACCESS   = 22;
   localparam int FS_LOCK_LSB     = 16;
   localparam int FS_CLR_ORDER    = 11;
   localparam int FS_CLR_COLD     = 10;
   localparam int FS_CLR_WARM     = 9;
   localparam int FS_OC_BLOCK     = 8;
   localparam int FS_BOOT_CLK     = 7;
   localparam int FS_FABRIC_BOOT  = 6;
   localparam int FS_AES_EN       = 5;
   localparam int FS_KEY_SRC_LSB  = 2;
   localparam int FS_KEY_LEN      = 1;
   localparam int FS_AUTH_EN      = 0;
   localparam logic [31:0] FS_DEFINED_MASK = 32'h07ff_0fff;

   // boot status word fields
   localparam int BS_CODE_LSB     = 0;
   localparam int BS_IF_LSB       = 3;
   localparam int BS_HIGH_V       = 5;
   localparam int BS_INVALID      = 6;
   localparam int BS_FABRIC       = 7;
   localparam int BS_CLK_BYPASS   = 8;
   localparam int BS_INT_LS_CLK   = 9;
   localparam int BS_OC_ALLOWED   = 10;
   localparam int BS_DECRYPT      = 11;
   localparam int BS_AUTH         = 12;
   localparam int BS_SCAN_BYPASS  = 13;
   localparam int BS_USER_CODE    = 14;
   localparam int BS_VALID        = 15;

   // debug control word fields
   localparam int DC_LEVEL_LSB    = 0;
   localparam int DC_SCAN_BYPASS  = 8;
   localparam int DBG_DOMAINS     = 6;

   // boot source and clock-select codes
   localparam logic [2:0] BOOT_RESERVED = 3'h0;
   localparam logic [2:0] BOOT_FABRIC   = 3'h1;
   localparam logic [3:0] CLKSEL_BYPASS = 4'hf;
   localparam logic [3:0] CLKSEL_IGNORE = 4'h0;

   // reset values and timing
   localparam logic [31:0] FUSE_RST      = 32'h0000_0000;
   localparam logic [5:0]  DBG_LEVEL_RST = 6'h00;
   localparam logic [1:0]  SEC_LEVEL_RST = 2'h0;
   localparam logic [1:0]  SEC_LEVEL_MAX = 2'h3;
   localparam logic [1:0]  SETTLE_CYCLES = 2'h3;

   typedef enum logic [1:0] {IF_FABRIC, IF_NAND, IF_SDMMC, IF_QSPI} bsf_flash_if_t;
   typedef enum logic [1:0] {ST_SETTLE, ST_LATCH, ST_RUN} bsf_state_t;

endpackage

// *** hdl/bsf_fuse_status.sv ***
// boot security fuse status bank with boot source decode and wishbone slave
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module bsf_fuse_status (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   // wishbone classic slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   // boot pins and fuse array
   input  wire logic [2:0]            bootSourcePins,
   input  wire logic [3:0]            fuseClkSel,
   input  wire logic                  fuseDebugAccess,
   input  wire logic                  fuseJtagLock,
   input  wire logic                  fuseDebugPortLock,
   input  wire logic                  fuseCore0DebugLock,
   input  wire logic                  fuseCore1DebugLock,
   input  wire logic                  fuseTraceLock,
   input  wire logic                  fuseFabricDebugLock,
   input  wire logic                  fuseRamClearOrder,
   input  wire logic                  fuseRamClearCold,
   input  wire logic                  fuseRamClearWarm,
   input  wire logic                  fuseOnchipRamBootBlock,
   input  wire logic                  fuseBootClkInternal,
   input  wire logic                  fuseForceFabricBoot,
   input  wire logic                  fuseAesEnable,
   input  wire logic [2:0]            fuseKeySource,
   input  wire logic                  fuseKeyLen,
   input  wire logic                  fuseAuthEnable,
   input  wire logic                  fuseScanBypass,
   // system events
   input  wire logic                  coldResetEvent,
   input  wire logic                  warmResetEvent,
   input  wire logic                  tamperEvent,
   input  wire logic                  fabricRaiseSecurity,
   input  wire logic                  userCodeRunning,
   input  wire logic                  sysMgrOnchipBootEnable,
   // boot side outputs
   output logic                       statusValid,
   output logic      [2:0]            bootSourceCode,
   output bsf_pkg::bsf_flash_if_t     bootFlashIf,
   output logic                       bootHighVoltage,
   output logic                       bootSourceInvalid,
   output logic                       bootFromFabric,
   output logic                       clkBypassMode,
   output logic      [3:0]            clkSelOut,
   output logic                       bootClkInternalLs,
   output logic      [5:0]            debugAccessLevel,
   output logic      [5:0]            debugLocks,
   output logic                       scanChainBypass,
   output logic                       onchipBootAllowed,
   output logic                       decryptForced,
   output logic                       authRequired,
   output logic      [2:0]            keySource,
   output logic                       keyLen384,
   output logic                       ramClearReq,
   output logic                       ramClearSerial,
   output logic      [1:0]            securityLevel
);
   import bsf_pkg::*;

   // all state of the block
   typedef struct packed {
      logic [31:0]   fuseS1;
      logic [31:0]   fuseS2;
      logic [2:0]    pinS1;
      logic [2:0]    pinS2;
      logic [5:0]    sideS1;
      logic [5:0]    sideS2;
      logic [5:0]    sidePrev;
      bsf_state_t    state;
      logic [1:0]    settleCnt;
      logic [31:0]   fuse;
      logic          valid;
      logic [2:0]    bootCode;
      bsf_flash_if_t bootIf;
      logic          bootHighV;
      logic          bootInvalid;
      logic          bootFabric;
      logic          clkBypass;
      logic [3:0]    clkSel;
      logic          intLsClk;
      logic [5:0]    dbgLevel;
      logic          softBypass;
      logic          scanFuse;
      logic          scanBypass;
      logic          ocAllowed;
      logic          decrypt;
      logic          auth;
      logic [2:0]    keySrc;
      logic          keyLen;
      logic [1:0]    secLevel;
      logic          ramClrReq;
      logic          ramClrSerial;
      logic          wbAck;
      logic [31:0]   wbDat;
   } bsf_regs_t;

   bsf_regs_t   q;
   bsf_regs_t   n;
   logic [31:0] fuseIn;
   logic [5:0]  sideIn;

   // raw fuse word, reserved fields held at zero
   assign fuseIn = {5'h00, fuseClkSel, fuseDebugAccess, fuseJtagLock, fuseDebugPortLock,
                    fuseCore0DebugLock, fuseCore1DebugLock, fuseTraceLock,
                    fuseFabricDebugLock, 4'h0, fuseRamClearOrder, fuseRamClearCold,
                    fuseRamClearWarm, fuseOnchipRamBootBlock, fuseBootClkInternal,
                    fuseForceFabricBoot, fuseAesEnable, fuseKeySource, fuseKeyLen,
                    fuseAuthEnable}; // [R3]

   // side inputs: cold, warm, tamper, fabric raise, user code, scan bypass fuse
   assign sideIn = {fuseScanBypass, userCodeRunning, fabricRaiseSecurity,
                    tamperEvent, warmResetEvent, coldResetEvent};

   // next-state logic
   always_comb begin
      logic [31:0] f;
      logic [2:0]  pins;
      logic [5:0]  edges;
      logic [5:0]  locks;
      logic        hit;
      logic        wrStb;
      logic [31:0] rdData;
      logic [31:0] bootWord;
      f        = q.fuseS2 & FS_DEFINED_MASK;
      pins     = q.pinS2;
      edges    = q.sideS2 & ~q.sidePrev;
      locks    = q.fuse[FS_LOCK_LSB +: DBG_DOMAINS];
      hit      = wb_cyc_i & wb_stb_i;
      wrStb    = hit & wb_we_i & q.wbAck;
      rdData   = UNMAPPED_DATA;
      bootWord = 32'h0000_0000;
      n        = q;

      // two-flop synchronisers for pins and fuse lines
      n.fuseS1   = fuseIn;
      n.fuseS2   = q.fuseS1;
      n.pinS1    = bootSourcePins;
      n.pinS2    = q.pinS1;
      n.sideS1   = sideIn;
      n.sideS2   = q.sideS1;
      n.sidePrev = q.sideS2;
      n.ramClrReq = 1'b0;

      // capture sequence after reset release
      case (q.state)
         ST_SETTLE: begin
            if (q.settleCnt == SETTLE_CYCLES) begin
               n.state = ST_LATCH;
            end else begin
               n.settleCnt = q.settleCnt + 2'h1;
            end
         end
         ST_LATCH: begin
            n.fuse       = f;                                   // [R4]
            n.valid      = 1'b1;
            n.dbgLevel   = {DBG_DOMAINS{f[FS_DBG_ACCESS]}};    // [R5]
            n.scanFuse   = q.sideS2[5];
            n.intLsClk   = f[FS_BOOT_CLK];                      // [R15]
            n.ocAllowed  = sysMgrOnchipBootEnable & ~f[FS_OC_BLOCK]; // [R14]
            n.decrypt    = f[FS_AES_EN];                        // [R16]
            n.keySrc     = f[FS_KEY_SRC_LSB +: 3];              // [R17]
            n.keyLen     = f[FS_KEY_LEN];                       // [R18]
            n.auth       = f[FS_AUTH_EN];                       // [R19]
            if (f[FS_FABRIC_BOOT]) begin
               // fabric only; pins and clock-select fuses ignored
               n.bootCode  = BOOT_FABRIC;                       // [R2]
               n.clkSel    = CLKSEL_IGNORE;                     // [R2]
               n.clkBypass = 1'b0;                              // [R2]
            end else begin
               n.bootCode  = pins;                              // [R1]
               n.clkSel    = f[FS_CLKSEL_LSB +: 4];             // [R4]
               n.clkBypass = (f[FS_CLKSEL_LSB +: 4] == CLKSEL_BYPASS); // [R23]
            end
            n.bootFabric  = f[FS_FABRIC_BOOT] | (pins == BOOT_FABRIC);
            n.bootInvalid = ~f[FS_FABRIC_BOOT] & (pins == BOOT_RESERVED); // [R1]
            n.bootHighV   = ~f[FS_FABRIC_BOOT] & pins[0];        // [R1]
            if (f[FS_FABRIC_BOOT] || pins[2:1] == 2'h0) begin
               n.bootIf = IF_FABRIC;
            end else if (pins[2:1] == 2'h1) begin
               n.bootIf = IF_NAND;                              // [R1]
            end else if (pins[2:1] == 2'h2) begin
               n.bootIf = IF_SDMMC;                             // [R1]
            end else begin
               n.bootIf = IF_QSPI;                              // [R1]
            end
            n.state = ST_RUN;
         end
         ST_RUN: begin
            // RAM clearing on resets, tamper takes priority
            if ((edges[0] && q.fuse[FS_CLR_COLD]) ||             // [R12]
                (edges[1] && q.fuse[FS_CLR_WARM])) begin         // [R13]
               n.ramClrReq    = 1'b1;
               n.ramClrSerial = 1'b0;
            end
            if (edges[2]) begin
               n.ramClrReq    = 1'b1;
               n.ramClrSerial = q.fuse[FS_CLR_ORDER];           // [R11]
            end
            // the on-chip boot permit follows the system manager enable
            n.ocAllowed = sysMgrOnchipBootEnable & ~q.fuse[FS_OC_BLOCK]; // [R14]
         end
         default: begin
            n.state = ST_SETTLE;
         end
      endcase

      // scan chain bypass: fuse is permanent, soft bit can be undone
      n.scanBypass = q.scanFuse | q.softBypass;                 // [R20]

      // fabric may raise security before or after boot, but only while user code is not running
      if (edges[3] && !q.sideS2[4] && q.secLevel != SEC_LEVEL_MAX) begin
         n.secLevel = q.secLevel + 2'h1;                        // [R21]
      end

      // wishbone classic: ack one cycle after the request, dropped after
      n.wbAck = hit & ~q.wbAck;

      // boot status word
      bootWord[BS_CODE_LSB +: 3] = q.bootCode;
      bootWord[BS_IF_LSB +: 2]   = q.bootIf;
      bootWord[BS_HIGH_V]        = q.bootHighV;
      bootWord[BS_INVALID]       = q.bootInvalid;
      bootWord[BS_FABRIC]        = q.bootFabric;
      bootWord[BS_CLK_BYPASS]    = q.clkBypass;
      bootWord[BS_INT_LS_CLK]    = q.intLsClk;
      bootWord[BS_OC_ALLOWED]    = q.ocAllowed;
      bootWord[BS_DECRYPT]       = q.decrypt;
      bootWord[BS_AUTH]          = q.auth;
      bootWord[BS_SCAN_BYPASS]   = q.scanBypass;
      bootWord[BS_USER_CODE]     = q.sideS2[4];
      bootWord[BS_VALID]         = q.valid;

      // read mux
      case (wb_adr_i)
         OFS_FUSE_STATUS: rdData = q.fuse;                      // [R22]
         OFS_BOOT_STATUS: rdData = bootWord;
         OFS_DEBUG_CTRL: begin
            rdData[DC_LEVEL_LSB +: DBG_DOMAINS] = q.dbgLevel;
            rdData[DC_SCAN_BYPASS]              = q.softBypass;
         end
         OFS_SEC_LEVEL: rdData[1:0] = q.secLevel;
         default: rdData = UNMAPPED_DATA;
      endcase
      if (hit && !q.wbAck) begin
         n.wbDat = rdData;
      end else begin
         n.wbDat = UNMAPPED_DATA;
      end

      // writes take effect on the edge that sees ack high
      if (wrStb) begin
         case (wb_adr_i)
            OFS_DEBUG_CTRL: begin
               if (wb_sel_i[0] && q.state == ST_RUN) begin
                  for (int i = 0; i < DBG_DOMAINS; i++) begin
                     if (!locks[i]) begin                       // [R6] [R7] [R8] [R9] [R10]
                        n.dbgLevel[i] = wb_dat_i[DC_LEVEL_LSB + i];
                     end
                  end
               end
               if (wb_sel_i[1]) begin
                  n.softBypass = wb_dat_i[DC_SCAN_BYPASS];      // [R20]
               end
            end
            OFS_SEC_LEVEL: begin
               // raise only, and only until user code runs
               if (wb_sel_i[0] && !q.sideS2[4] && wb_dat_i[1:0] > n.secLevel) begin
                  n.secLevel = wb_dat_i[1:0];                   // [R21]
               end
            end
            default: begin
               // fuse and boot status words ignore writes
               n.fuse = n.fuse;                                 // [R24]
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q          <= '0;
         q.state    <= ST_SETTLE;
         q.fuse     <= FUSE_RST;
         q.dbgLevel <= DBG_LEVEL_RST;
         q.secLevel <= SEC_LEVEL_RST;
      end else begin
         q <= n;
      end
   end

   // outputs straight from state
   assign wb_dat_o          = q.wbDat;
   assign wb_ack_o          = q.wbAck;
   assign statusValid       = q.valid;
   assign bootSourceCode    = q.bootCode;
   assign bootFlashIf       = q.bootIf;
   assign bootHighVoltage   = q.bootHighV;
   assign bootSourceInvalid = q.bootInvalid;
   assign bootFromFabric    = q.bootFabric;
   assign clkBypassMode     = q.clkBypass;
   assign clkSelOut         = q.clkSel;
   assign bootClkInternalLs = q.intLsClk;
   assign debugAccessLevel  = q.dbgLevel;
   assign debugLocks        = q.fuse[FS_LOCK_LSB +: DBG_DOMAINS];
   assign scanChainBypass   = q.scanBypass;
   assign onchipBootAllowed = q.ocAllowed;
   assign decryptForced     = q.decrypt;
   assign authRequired      = q.auth;
   assign keySource         = q.keySrc;
   assign keyLen384         = q.keyLen;
   assign ramClearReq       = q.ramClrReq;
   assign ramClearSerial    = q.ramClrSerial;
   assign securityLevel     = q.secLevel;

endmodule // bsf_fuse_status

// *** bench/bsf_fuse_status_asserts.sv ***
// concurrent checks on the ports of the fuse status bank
`timescale 1ns/1ps
module bsf_fuse_status_asserts import bsf_pkg::*; (
   input wire logic                   clk,
   input wire logic                   arst_n,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_we_i,
   input wire logic [7:0]             wb_adr_i,
   input wire logic [31:0]            wb_dat_o,
   input wire logic                   wb_ack_o,
   input wire logic [2:0]             bootSourcePins,
   input wire logic                   fuseForceFabricBoot,
   input wire logic                   fuseOnchipRamBootBlock,
   input wire logic                   fuseRamClearOrder,
   input wire logic                   tamperEvent,
   input wire logic                   sysMgrOnchipBootEnable,
   input wire logic                   statusValid,
   input wire logic [2:0]             bootSourceCode,
   input wire bsf_pkg::bsf_flash_if_t bootFlashIf,
   input wire logic                   bootFromFabric,
   input wire logic                   clkBypassMode,
   input wire logic [3:0]             clkSelOut,
   input wire logic                   bootClkInternalLs,
   input wire logic [5:0]             debugLocks,
   input wire logic                   onchipBootAllowed,
   input wire logic                   decryptForced,
   input wire logic                   authRequired,
   input wire logic [2:0]             keySource,
   input wire logic                   keyLen384,
   input wire logic                   ramClearReq,
   input wire logic                   ramClearSerial
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // request taken, status word answered after capture, tamper seen after capture
   sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence fsRead_s; wb_ack_o && !wb_we_i && wb_adr_i == OFS_FUSE_STATUS && statusValid; endsequence
   sequence tamper_s; $rose(tamperEvent) && statusValid; endsequence
   ack_one_pulse_a: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus request not answered by a single ack");
   reserved_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_FUSE_STATUS
      |-> (wb_dat_o & ~FS_DEFINED_MASK) == 32'h0000_0000) else $error("reserved bits set");
   clk_sel_view_a: assert property (fsRead_s
      |-> clkSelOut == (wb_dat_o[6] ? CLKSEL_IGNORE : wb_dat_o[26:23])) else $error("clock select");
   bypass_mode_a: assert property (fsRead_s
      |-> clkBypassMode == (!wb_dat_o[6] && wb_dat_o[26:23] == CLKSEL_BYPASS)) else $error("bypass");
   debug_locks_a: assert property (fsRead_s |-> debugLocks == wb_dat_o[21:16])
      else $error("debug locks differ from status word");
   crypto_view_a: assert property (fsRead_s
      |-> {decryptForced, authRequired, keySource, keyLen384, bootClkInternalLs}
          == {wb_dat_o[5], wb_dat_o[0], wb_dat_o[4:2], wb_dat_o[1], wb_dat_o[7]})
      else $error("boot security outputs differ from status word");
   fabric_force_a: assert property (statusValid && fuseForceFabricBoot
      |-> bootFromFabric && bootSourceCode == BOOT_FABRIC) else $error("forced fabric boot");
   pin_decode_a: assert property (statusValid && !fuseForceFabricBoot
      && bootSourcePins != BOOT_RESERVED |-> bootSourceCode == bootSourcePins
      && bootFlashIf == bsf_flash_if_t'(bootSourcePins[2:1])) else $error("pin decode");
   onchip_gate_a: assert property (statusValid && $past(statusValid) |-> onchipBootAllowed
      == ($past(sysMgrOnchipBootEnable) && !fuseOnchipRamBootBlock)) else $error("onchip boot");
   tamper_clear_a: assert property (tamper_s
      |-> ##[2:6] (ramClearReq && ramClearSerial == fuseRamClearOrder)) else $error("tamper clear");
endmodule // bsf_fuse_status_asserts

// *** bench/bsf_fuse_model.sv ***
// fuse array model feeding the fuse inputs of the status bank
`timescale 1ns/1ps
module bsf_fuse_model (
   input  wire logic [31:0] fuseWord,
   input  wire logic        scanFuse,
   output logic      [3:0]  clkSel,
   output logic             dbgAccess,
   output logic      [5:0]  locks,
   output logic      [11:0] low,
   output logic             scanBypass
);
   // blown fuses laid out as in the status word, static while powered
   assign clkSel = fuseWord[26:23];
   assign dbgAccess = fuseWord[22];
   assign locks = fuseWord[21:16];
   assign low = fuseWord[11:0];
   assign scanBypass = scanFuse;
endmodule // bsf_fuse_model

// *** bench/bsf_fuse_status_bench.sv ***
// self-checking bench for the fuse status bank
`timescale 1ns/1ps
module bsf_fuse_status_bench;
   import bsf_pkg::*;
   logic clk, arst_n, cyc, stb, we, ack, scanFuse, raise, userRun, ocEn, sv, got, ser;
   logic bhv, binv, bfab, cbyp, bls, scb, oba, dec, aut, k384, rcr, rcs, da, sb;
   logic [2:0] pins, pv, bsc, ksrc, evt;
   logic [3:0] csel, cs;
   logic [5:0] dal, dlk, lk;
   logic [11:0] lo;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, dout, fw;
   logic [1:0] sec;
   bsf_flash_if_t bfi;
   int fails, checksDone;
   localparam logic [31:0] CFG_A = 32'hff95_fea9;
   localparam logic [31:0] CFG_B = 32'h07d1_0140;

   bsf_fuse_model fm_u (.fuseWord(fw), .scanFuse(scanFuse), .clkSel(cs), .dbgAccess(da),
      .locks(lk), .low(lo), .scanBypass(sb));
   bsf_fuse_status dut_u (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout),
      .wb_ack_o(ack), .bootSourcePins(pins), .fuseClkSel(cs), .fuseDebugAccess(da),
      .fuseJtagLock(lk[5]), .fuseDebugPortLock(lk[4]), .fuseCore0DebugLock(lk[3]),
      .fuseCore1DebugLock(lk[2]), .fuseTraceLock(lk[1]), .fuseFabricDebugLock(lk[0]),
      .fuseRamClearOrder(lo[11]), .fuseRamClearCold(lo[10]), .fuseRamClearWarm(lo[9]),
      .fuseOnchipRamBootBlock(lo[8]), .fuseBootClkInternal(lo[7]), .fuseForceFabricBoot(lo[6]),
      .fuseAesEnable(lo[5]), .fuseKeySource(lo[4:2]), .fuseKeyLen(lo[1]), .fuseAuthEnable(lo[0]),
      .fuseScanBypass(sb), .coldResetEvent(evt[1]), .warmResetEvent(evt[0]),
      .tamperEvent(evt[2]), .fabricRaiseSecurity(raise), .userCodeRunning(userRun),
      .sysMgrOnchipBootEnable(ocEn), .statusValid(sv), .bootSourceCode(bsc), .bootFlashIf(bfi),
      .bootHighVoltage(bhv), .bootSourceInvalid(binv), .bootFromFabric(bfab),
      .clkBypassMode(cbyp), .clkSelOut(csel), .bootClkInternalLs(bls), .debugAccessLevel(dal),
      .debugLocks(dlk), .scanChainBypass(scb), .onchipBootAllowed(oba), .decryptForced(dec),
      .authRequired(aut), .keySource(ksrc), .keyLen384(k384), .ramClearReq(rcr),
      .ramClearSerial(rcs), .securityLevel(sec));

   // free-running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // summary and verdict
   task automatic conclude();
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // one classic wishbone cycle, held until ack is sampled
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rdat = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // reset with a fuse image and pin code, then wait for capture
   task automatic boot(input logic [31:0] w, input logic [2:0] p);
      int n;
      @(posedge clk);
      arst_n <= 1'b0;
      fw <= w;
      pins <= p;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      n = 0;
      while (sv !== 1'b1 && n < 12) begin
         @(posedge clk);
         n++;
      end
      chk(sv, 1'b1);
   endtask

   // pulse one event input and watch for a clear request
   task automatic event_pulse(input int i, input logic expReq, input logic expSer);
      @(posedge clk);
      evt <= 3'(1 << i);
      got = 1'b0;
      for (int n = 0; n < 10; n++) begin
         @(posedge clk);
         if (rcr === 1'b1) begin
            got = 1'b1;
            ser = rcs;
         end
         if (n == 3) evt <= 3'h0;
      end
      chk(got, expReq);
      if (expReq) chk(ser, expSer);
   endtask

   // one fabric raise pulse through the synchroniser
   task automatic raise_pulse();
      @(posedge clk);
      raise <= 1'b1;
      repeat (3) @(posedge clk);
      raise <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // main sequence
   initial begin
      {arst_n, cyc, stb, we, scanFuse, raise, userRun, ocEn} = 8'h00;
      {adr, wdat, fw, pins, evt} = '0;
      for (int p = 0; p < 8; p++) begin
         pv = 3'(p);
         boot(32'h0000_0000, pv);
         chk(binv, p == 0);
         if (p != 0) chk({bhv, bfi, bsc}, {pv[0], pv[2:1], pv});
      end
      ocEn <= 1'b1;
      boot(CFG_A, 3'h6);
      xfer(OFS_FUSE_STATUS, 1'b0, 32'h0);
      chk(rdat, CFG_A & FS_DEFINED_MASK);
      chk({cbyp, csel, bfab, bsc}, {1'b1, 4'hf, 1'b0, 3'h6});
      chk({dec, aut, ksrc, k384, bls, oba}, 8'hd3);
      xfer(OFS_FUSE_STATUS, 1'b1, 32'hffff_ffff);
      xfer(OFS_FUSE_STATUS, 1'b0, 32'h0);
      chk(rdat, CFG_A & FS_DEFINED_MASK);
      xfer(8'h10, 1'b0, 32'h0);
      chk(rdat, UNMAPPED_DATA);
      chk(dlk, 6'h15);
      xfer(OFS_DEBUG_CTRL, 1'b1, 32'h0000_013f);
      xfer(OFS_DEBUG_CTRL, 1'b0, 32'h0);
      chk(dal, 6'h2a);
      chk(scb, 1'b1);
      xfer(OFS_DEBUG_CTRL, 1'b1, 32'h0);
      xfer(OFS_DEBUG_CTRL, 1'b0, 32'h0);
      chk(scb, 1'b0);
      event_pulse(2, 1'b1, 1'b1);
      event_pulse(1, 1'b1, 1'b0);
      event_pulse(0, 1'b1, 1'b0);
      raise_pulse();
      chk(sec, 2'h1);
      xfer(OFS_SEC_LEVEL, 1'b1, 32'h2);
      userRun <= 1'b1;
      repeat (4) @(posedge clk);
      xfer(OFS_SEC_LEVEL, 1'b1, 32'h3);
      xfer(OFS_SEC_LEVEL, 1'b0, 32'h0);
      chk(rdat[1:0], 2'h2);
      userRun <= 1'b0;
      repeat (2) raise_pulse();
      chk(sec, 2'h3);
      scanFuse <= 1'b1;
      boot(CFG_B, 3'h6);
      chk({cbyp, csel, bfab, bsc, oba}, {1'b0, 4'h0, 1'b1, 3'h1, 1'b0});
      chk(dal, 6'h3f);
      xfer(OFS_BOOT_STATUS, 1'b0, 32'h0);
      chk(rdat, 32'h0000_a081);
      xfer(OFS_DEBUG_CTRL, 1'b1, 32'h0);
      xfer(OFS_DEBUG_CTRL, 1'b0, 32'h0);
      chk({scb, dal}, 7'h51);
      event_pulse(0, 1'b0, 1'b0);
      conclude();
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      conclude();
   end
endmodule // bsf_fuse_status_bench

bind bsf_fuse_status bsf_fuse_status_asserts chk_u (.clk(clk), .arst_n(arst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bootSourcePins(bootSourcePins),
   .fuseForceFabricBoot(fuseForceFabricBoot), .fuseOnchipRamBootBlock(fuseOnchipRamBootBlock),
   .fuseRamClearOrder(fuseRamClearOrder), .tamperEvent(tamperEvent),
   .sysMgrOnchipBootEnable(sysMgrOnchipBootEnable), .statusValid(statusValid),
   .bootSourceCode(bootSourceCode), .bootFlashIf(bootFlashIf), .bootFromFabric(bootFromFabric),
   .clkBypassMode(clkBypassMode), .clkSelOut(clkSelOut), .bootClkInternalLs(bootClkInternalLs),
   .debugLocks(debugLocks), .onchipBootAllowed(onchipBootAllowed),
   .decryptForced(decryptForced), .authRequired(authRequired), .keySource(keySource),
   .keyLen384(keyLen384), .ramClearReq(ramClearReq), .ramClearSerial(ramClearSerial));
